// ### core/ucr_pkg.sv
/*
 status, event latch, debug, scratch and car-kit register definitions
 assumes: byte-wide register port with 6-bit addresses in the link clock domain
*/
package ucr_pkg;
   localparam logic [5:0] ADDR_EVT_STATUS = 6'h13;
   localparam logic [5:0] ADDR_EVT_LATCH = 6'h14;
   localparam logic [5:0] ADDR_LINE_DEBUG = 6'h15;
   localparam logic [5:0] ADDR_SCRATCH_WR = 6'h16;
   localparam logic [5:0] ADDR_SCRATCH_SET = 6'h17;
   localparam logic [5:0] ADDR_SCRATCH_CLR = 6'h18;
   localparam logic [5:0] ADDR_CK_CTRL_WR = 6'h19;
   localparam logic [5:0] ADDR_CK_CTRL_SET = 6'h1a;
   localparam logic [5:0] ADDR_CK_CTRL_CLR = 6'h1b;
   localparam logic [5:0] ADDR_CK_IEN_WR = 6'h1d;
   localparam logic [5:0] ADDR_CK_IEN_SET = 6'h1e;
   localparam logic [5:0] ADDR_CK_IEN_CLR = 6'h1f;
   localparam logic [7:0] SCRATCH_RESET = 8'h00;
   localparam logic [7:0] CK_CTRL_RESET = 8'h00;
   localparam logic [7:0] CK_IEN_RESET = 8'h00;
   localparam logic [4:0] EDGE_EN_RESET = 5'h1f;
   // writable bits; bit 0 of control and bits 3,4,6,7 of enable read zero
   localparam logic [7:0] CK_CTRL_WMASK = 8'hfe;
   localparam logic [7:0] CK_IEN_WMASK = 8'h27;
   localparam int EVT_HOST_DISC = 0;
   localparam int EVT_BUS_PWR = 1;
   localparam int EVT_SESSION_OK = 2;
   localparam int EVT_SESSION_OVER = 3;
   localparam int EVT_ID_GROUNDED = 4;
   localparam int CK_ID_PULL_LOW = 1;
   localparam int CK_UART_TX = 2;
   localparam int CK_UART_RX = 3;
   localparam int CK_DATA2_TRI = 7;
   localparam int IEN_ID_OPEN_RISE = 0;
   localparam int IEN_ID_OPEN_FALL = 1;
   localparam int IEN_DATA_DETECT = 2;
   localparam int IEN_RES_CONV = 5;
   typedef enum logic [1:0] {UCR_ST_ULPI = 2'b00, UCR_ST_CARKIT = 2'b01} ucr_mode_e;
endpackage

// ### core/ucr_wsc.sv
/*
 byte register with write, set and clear strobes
 assumes: at most one strobe per cycle from the register decoder
*/
`timescale 1ns/10ps
module ucr_wsc #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WMASK = 8'hff
) (
   input wire logic ref_clk,      // clock
   input wire logic rst_b,        // async reset, low
   input wire logic wr,           // write strobe
   input wire logic set,          // set strobe
   input wire logic clr,          // clear strobe
   input wire logic [7:0] wdata,  // written byte
   output logic [7:0] q           // register value
);
   typedef struct packed {
      logic [7:0] val;
   } ucr_wsc_s;
   ucr_wsc_s st;
   ucr_wsc_s next_st;

   always_comb
   begin
      next_st = st;
      if (wr)
         next_st.val = wdata & WMASK;
      else if (set)
         next_st.val = (st.val | wdata) & WMASK;
      else if (clr)
         next_st.val = st.val & ~wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         st <= '{val: RESET_VAL};
      else
         st <= next_st;
   end

   assign q = st.val;
endmodule

// ### core/ucr_regs.sv
/*
 usb status/latch/debug/scratch and car-kit control registers
 assumes: reg_rd/reg_wr single-cycle strobes from the ulpi register engine,
 comparator inputs synchronous to ref_clk, edge enables from elsewhere
*/
// Function
// - status byte at 0x13 follows comparator outputs live, unlatched.
// - status bit 0 is host-disconnect, meaningful in host mode.
// - status bit 1 is bus-power-valid, reads 0 when both edge enables set.
// - status bit 2 always shows live session-valid comparator.
// - status bit 3 is session-end, reads 0 when both edge enables set.
// - status bit 4 is id-grounded; bits 7:5 read zero.
// - zero default only after reset; reads sample comparators at read time.
// - latch byte at 0x14, same order, set by enabled edges.
// - reading latch byte returns it then clears it; bits 7:5 zero.
// - rising or falling enable must be set for an event; default 1.
// - debug byte at 0x15 shows line state in bits 1:0.
// - scratch byte, reset 0, read/write 0x16, set 0x17, clear 0x18.
// - mode bit remaps ulpi pins; device clears it when leaving.
// - with receive routing off, data line 1 is held high.
// - control bit 2 routes tx to dm, bit 3 routes dp to data 1.
// - control bit 1 grounds id; bit 0 reads zero; 6:4 writable.
// - bit 7 set tri-states data line 2 in car-kit mode, else drive 0.
// - interrupt enables raise alt interrupt on id float and data detect.
// - bit 5 raises alt interrupt on conversion done, ORed with vendor bit.
// - enable bits 3,4,6,7 read zero.
`timescale 1ns/10ps
module ucr_regs (
   input wire logic ref_clk,                 // 50 mhz clock
   input wire logic rst_b,                   // async reset, low
   input wire logic reg_wr,                  // register write strobe
   input wire logic reg_rd,                  // register read strobe
   input wire logic [5:0] reg_addr,          // register address
   input wire logic [7:0] reg_wdata,         // write data
   output logic [7:0] reg_rdata,             // read data, valid cycle after reg_rd
   input wire logic host_disconnect,         // hs host-disconnect detector
   input wire logic bus_power_valid,         // bus-power-valid comparator
   input wire logic session_ok,              // session-valid comparator
   input wire logic session_over,            // session-end comparator
   input wire logic id_pin_grounded,         // id-grounded detector
   input wire logic [1:0] line_state,        // bus line state
   input wire logic [4:0] rise_enable,       // rising event enables
   input wire logic [4:0] fall_enable,       // falling event enables
   input wire logic car_accessory_mode,      // car-kit mode bit from interface control
   input wire logic id_open,                 // id pin floating detector
   input wire logic data_detect,             // data-detect comparator
   input wire logic resistor_conv_finished,  // resistor conversion done
   input wire logic vendor_conv_irq_enable,  // duplicate enable in vendor register
   input wire logic uart_tx_in,              // uart tx from link on data 0
   input wire logic dp_in,                   // dp receiver level
   output logic car_mode_exit,               // pulse: clear car-kit mode bit
   output logic id_pin_pull_low,             // ground the id pin
   output logic uart_tx_route_on,            // data 0 drives dm
   output logic uart_rx_route_on,            // dp drives data 1
   output logic dm_uart_out,                 // uart level onto dm
   output logic data1_out,                   // data 1 output level
   output logic data1_oe,                    // data 1 output enable
   output logic data2_out,                   // data 2 output level
   output logic data2_oe,                    // data 2 output enable
   output logic alt_int                      // alternate interrupt pulse to rx cmd
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] rdata;
      logic [4:0] latch;
      logic [4:0] prev_src;
      logic prev_id_open;
      logic prev_data_det;
      logic prev_conv;
      logic alt;
      logic mode_exit;
      logic prev_mode;
      logic pull_low;
      logic tx_on;
      logic rx_on;
      logic dm_out;
      logic d1_out;
      logic d1_oe;
      logic d2_out;
      logic d2_oe;
   } ucr_regs_s;
   ucr_regs_s st;
   ucr_regs_s next_st;
   logic [7:0] scratch_byte;
   logic [7:0] carkit_uart_control;
   logic [7:0] carkit_event_enable;
   logic [4:0] src;
   logic [4:0] edge_evt;
   logic [7:0] usb_event_status;
   logic ck_mode;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
      hit = (a == b);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   ucr_wsc #(.RESET_VAL(ucr_pkg::SCRATCH_RESET), .WMASK(8'hff)) u_scratch (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .wr(reg_wr && hit(reg_addr, ucr_pkg::ADDR_SCRATCH_WR)),
      .set(reg_wr && hit(reg_addr, ucr_pkg::ADDR_SCRATCH_SET)),
      .clr(reg_wr && hit(reg_addr, ucr_pkg::ADDR_SCRATCH_CLR)),
      .wdata(reg_wdata),
      .q(scratch_byte)
   );

   // control bit 0 is masked out so it always reads zero
   ucr_wsc #(.RESET_VAL(ucr_pkg::CK_CTRL_RESET), .WMASK(ucr_pkg::CK_CTRL_WMASK)) u_ctrl (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .wr(reg_wr && hit(reg_addr, ucr_pkg::ADDR_CK_CTRL_WR)),
      .set(reg_wr && hit(reg_addr, ucr_pkg::ADDR_CK_CTRL_SET)),
      .clr(reg_wr && hit(reg_addr, ucr_pkg::ADDR_CK_CTRL_CLR)),
      .wdata(reg_wdata),
      .q(carkit_uart_control)
   );

   ucr_wsc #(.RESET_VAL(ucr_pkg::CK_IEN_RESET), .WMASK(ucr_pkg::CK_IEN_WMASK)) u_ien (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .wr(reg_wr && hit(reg_addr, ucr_pkg::ADDR_CK_IEN_WR)),
      .set(reg_wr && hit(reg_addr, ucr_pkg::ADDR_CK_IEN_SET)),
      .clr(reg_wr && hit(reg_addr, ucr_pkg::ADDR_CK_IEN_CLR)),
      .wdata(reg_wdata),
      .q(carkit_event_enable)
   );

   ////////////////////////////////////////////////////////////////////////////////
   assign src = {id_pin_grounded, session_over, session_ok, bus_power_valid, host_disconnect};
   // an event only counts when the enable for its direction is set
   assign edge_evt = (src & ~st.prev_src & rise_enable) | (~src & st.prev_src & fall_enable);
   assign ck_mode = car_accessory_mode;

   always_comb
   begin
      usb_event_status = 8'h00;
      usb_event_status[ucr_pkg::EVT_HOST_DISC] = host_disconnect;
      usb_event_status[ucr_pkg::EVT_BUS_PWR] = bus_power_valid
         && !(rise_enable[ucr_pkg::EVT_BUS_PWR] && fall_enable[ucr_pkg::EVT_BUS_PWR]);
      usb_event_status[ucr_pkg::EVT_SESSION_OK] = session_ok;
      usb_event_status[ucr_pkg::EVT_SESSION_OVER] = session_over
         && !(rise_enable[ucr_pkg::EVT_SESSION_OVER]
         && fall_enable[ucr_pkg::EVT_SESSION_OVER]);
      usb_event_status[ucr_pkg::EVT_ID_GROUNDED] = id_pin_grounded;
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_st = st;
      next_st.prev_src = src;
      next_st.prev_id_open = id_open;
      next_st.prev_data_det = data_detect;
      next_st.prev_conv = resistor_conv_finished;
      next_st.prev_mode = ck_mode;

      // read data is sampled in the read cycle, so it shows that moment's comparators
      if (reg_rd)
      begin
         case (reg_addr)
            ucr_pkg::ADDR_EVT_STATUS: next_st.rdata = usb_event_status;
            ucr_pkg::ADDR_EVT_LATCH: next_st.rdata = {3'h0, st.latch};
            ucr_pkg::ADDR_LINE_DEBUG: next_st.rdata = {6'h00, line_state};
            ucr_pkg::ADDR_SCRATCH_WR,
            ucr_pkg::ADDR_SCRATCH_SET,
            ucr_pkg::ADDR_SCRATCH_CLR: next_st.rdata = scratch_byte;
            ucr_pkg::ADDR_CK_CTRL_WR,
            ucr_pkg::ADDR_CK_CTRL_SET,
            ucr_pkg::ADDR_CK_CTRL_CLR: next_st.rdata = carkit_uart_control;
            ucr_pkg::ADDR_CK_IEN_WR,
            ucr_pkg::ADDR_CK_IEN_SET,
            ucr_pkg::ADDR_CK_IEN_CLR: next_st.rdata = carkit_event_enable;
            default: next_st.rdata = 8'h00;
         endcase
      end

      // set wins over the read-clear so a coincident event is not lost
      if (reg_rd && hit(reg_addr, ucr_pkg::ADDR_EVT_LATCH))
         next_st.latch = edge_evt;
      else
         next_st.latch = st.latch | edge_evt;

      next_st.alt =
         (carkit_event_enable[ucr_pkg::IEN_ID_OPEN_RISE] && id_open && !st.prev_id_open)
         || (carkit_event_enable[ucr_pkg::IEN_ID_OPEN_FALL] && !id_open && st.prev_id_open)
         || (carkit_event_enable[ucr_pkg::IEN_DATA_DETECT]
             && (data_detect != st.prev_data_det))
         || ((carkit_event_enable[ucr_pkg::IEN_RES_CONV] || vendor_conv_irq_enable)
             && resistor_conv_finished && !st.prev_conv);

      // leaving car-kit mode is seen as the link dropping stp-driven mode; the bit
      // owner clears on this pulse
      next_st.mode_exit = st.prev_mode && !ck_mode;

      next_st.pull_low = carkit_uart_control[ucr_pkg::CK_ID_PULL_LOW];
      next_st.tx_on = ck_mode && carkit_uart_control[ucr_pkg::CK_UART_TX];
      next_st.rx_on = ck_mode && carkit_uart_control[ucr_pkg::CK_UART_RX];
      next_st.dm_out = uart_tx_in;
      // data 1 is driven in car-kit mode: dp level when routed, else held high
      next_st.d1_oe = ck_mode;
      next_st.d1_out = carkit_uart_control[ucr_pkg::CK_UART_RX] ? dp_in : 1'b1;
      next_st.d2_out = 1'b0;
      next_st.d2_oe = ck_mode && !carkit_uart_control[ucr_pkg::CK_DATA2_TRI];
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         st <= '0;
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign reg_rdata = st.rdata;
   assign car_mode_exit = st.mode_exit;
   assign id_pin_pull_low = st.pull_low;
   assign uart_tx_route_on = st.tx_on;
   assign uart_rx_route_on = st.rx_on;
   assign dm_uart_out = st.dm_out;
   assign data1_out = st.d1_out;
   assign data1_oe = st.d1_oe;
   assign data2_out = st.d2_out;
   assign data2_oe = st.d2_oe;
   assign alt_int = st.alt;
endmodule

// ### tb/ucr_regs_asserts.sv
/*
 port checker for ucr_regs
 assumes: bound to ucr_regs, one clock domain
*/
`timescale 1ns/10ps
module ucr_regs_chk (
   input wire logic ref_clk, // clock
   input wire logic rst_b, // reset
   input wire logic reg_rd, // read
   input wire logic [5:0] reg_addr, // address
   input wire logic [7:0] reg_rdata, // read data
   input wire logic session_ok, // comparator
   input wire logic [1:0] line_state, // lines
   input wire logic [4:0] rise_enable, // enables
   input wire logic [4:0] fall_enable, // enables
   input wire logic car_accessory_mode, // mode
   input wire logic uart_tx_in, // tx in
   input wire logic dm_uart_out, // dm
   input wire logic uart_rx_route_on, // rx route
   input wire logic data1_out, // data 1
   input wire logic data1_oe, // data 1 oe
   input wire logic data2_out, // data 2
   input wire logic data2_oe, // data 2 oe
   input wire logic car_mode_exit, // exit pulse
   input wire logic alt_int // alt interrupt
);
logic rd_d;
logic [5:0] ad_d;
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_b);
always_ff @(posedge ref_clk or negedge rst_b)
   if (!rst_b)
   begin
      rd_d <= 1'b0;
      ad_d <= 6'h00;
   end
   else
   begin
      rd_d <= reg_rd;
      ad_d <= reg_addr;
   end
rsv_zero_a:
   assert property (rd_d && ad_d inside {6'h13, 6'h14} |-> reg_rdata[7:5] == 3'h0)
   else $error("status or latch high bits set");
sess_live_a:
   assert property (rd_d && ad_d == 6'h13 && $past(session_ok, 2) == $past(session_ok)
      |-> reg_rdata[2] == $past(session_ok)) else $error("session bit not live");
pwr_mask_a:
   assert property (rd_d && ad_d == 6'h13 && $past(rise_enable[1] && fall_enable[1])
      |-> !reg_rdata[1]) else $error("bus power bit not masked");
end_mask_a:
   assert property (rd_d && ad_d == 6'h13 && $past(rise_enable[3] && fall_enable[3])
      |-> !reg_rdata[3]) else $error("session end bit not masked");
dbg_lines_a:
   assert property (rd_d && ad_d == 6'h15 && $past(line_state, 2) == $past(line_state)
      |-> reg_rdata == {6'h00, $past(line_state)}) else $error("debug byte wrong");
ctl_bit0_a:
   assert property (rd_d && ad_d inside {[6'h19:6'h1b]} |-> !reg_rdata[0])
   else $error("control bit 0 set");
ien_rsv_a:
   assert property (rd_d && ad_d inside {[6'h1d:6'h1f]} |-> (reg_rdata & 8'hd8) == 8'h00)
   else $error("enable reserved bits set");
rx_hold_a:
   assert property (data1_oe && !uart_rx_route_on |-> data1_out) else $error("data 1 not high");
d2_drive_a:
   assert property (data2_oe |-> !data2_out && $past(car_accessory_mode))
   else $error("data 2 drive wrong");
mode_exit_a:
   assert property ($fell(car_accessory_mode) |=> car_mode_exit ##1 !car_mode_exit)
   else $error("no exit pulse");
dm_copy_a:
   assert property ($past(rst_b) |-> dm_uart_out == $past(uart_tx_in))
   else $error("dm not following tx");
cover property (car_mode_exit);
cover property (alt_int);
cover property (rd_d && ad_d == 6'h14 && reg_rdata != 8'h00);
endmodule
bind ucr_regs ucr_regs_chk chk (.ref_clk, .rst_b, .reg_rd, .reg_addr, .reg_rdata, .session_ok,
   .line_state, .rise_enable, .fall_enable, .car_accessory_mode, .uart_tx_in, .dm_uart_out,
   .uart_rx_route_on, .data1_out, .data1_oe, .data2_out, .data2_oe, .car_mode_exit, .alt_int);

// ### tb/ucr_link.sv
/*
 link-side model: register transfers and the car-kit mode bit
 assumes: strobes are sampled on the rising edge of ref_clk
*/
`timescale 1ns/10ps
module ucr_link (
   input wire logic ref_clk, // clock
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [5:0] reg_addr, // address
   output logic [7:0] reg_wdata, // write data
   output logic car_accessory_mode // mode bit
);
initial
begin
   reg_wr = 1'b0;
   reg_rd = 1'b0;
   reg_addr = 6'h00;
   reg_wdata = 8'h00;
   car_accessory_mode = 1'b0;
end
task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
   @(posedge ref_clk);
   #2;
   reg_wr = w;
   reg_rd = !w;
   reg_addr = a;
   reg_wdata = d;
   @(posedge ref_clk);
   #2;
   reg_wr = 1'b0;
   reg_rd = 1'b0;
   // idle bus never keeps the old value, so stale data cannot pass
   reg_addr = ~a;
   reg_wdata = ~d;
endtask
task automatic car_on(input logic [7:0] c);
   xfer(1'b1, ucr_pkg::ADDR_CK_CTRL_WR, c);
   @(posedge ref_clk);
   #2;
   car_accessory_mode = 1'b1;
endtask
task automatic car_off();
   @(posedge ref_clk);
   #2;
   car_accessory_mode = 1'b0;
endtask
endmodule

// ### tb/ulpi_phy_status_carkit_regs_bench.sv
/*
 self-checking bench for ucr_regs
 assumes: ucr_link drives the register port and mode bit
*/
`timescale 1ns/10ps
module ulpi_phy_status_carkit_regs_bench;
logic ref_clk, rst_b, vend, seen, hit;
logic uart_tx_in = 1'b0;
logic dp_in = 1'b0;
logic [4:0] src, rise_enable, fall_enable, exp5;
logic [1:0] line_state;
logic [2:0] sig;
logic [8:0] e;
logic [31:0] seed = 32'hbd15630d;
logic [31:0] r;
logic [8:0] exp_q [$];
int n_errors = 0;
int tests_run = 0;
int cyc = 0;
logic [5:0] rv [7] = '{6'h13, 6'h14, 6'h16, 6'h19, 6'h1d, 6'h00, 6'h1c};
logic [7:0] ck [4] = '{8'h00, 8'h8e, 8'h0c, 8'h86};
logic [12:0] at [8] = '{13'h002, 13'h020, 13'h023, 13'h041, 13'h085, 13'h40d, 13'h004, 13'h01d};
wire reg_wr, reg_rd, car_accessory_mode, car_mode_exit, id_pin_pull_low, alt_int;
wire uart_tx_route_on, uart_rx_route_on, dm_uart_out, data1_out, data1_oe, data2_out, data2_oe;
wire [5:0] reg_addr;
wire [7:0] reg_wdata, reg_rdata;
ucr_link lnk (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .car_accessory_mode);
ucr_regs uut (.ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
   .host_disconnect(src[0]), .bus_power_valid(src[1]), .session_ok(src[2]),
   .session_over(src[3]), .id_pin_grounded(src[4]), .line_state, .rise_enable, .fall_enable,
   .car_accessory_mode, .id_open(sig[0]), .data_detect(sig[1]), .resistor_conv_finished(sig[2]),
   .vendor_conv_irq_enable(vend), .uart_tx_in, .dp_in, .car_mode_exit, .id_pin_pull_low,
   .uart_tx_route_on, .uart_rx_route_on, .dm_uart_out, .data1_out, .data1_oe, .data2_out,
   .data2_oe, .alt_int);
function logic [31:0] rnd();
   seed ^= seed << 13;
   seed ^= seed >> 17;
   seed ^= seed << 5;
   return seed;
endfunction
task chk(input logic [7:0] got, input logic [7:0] want);
   tests_run++;
   if (got !== want)
   begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
   end
endtask
task rd(input logic [5:0] a, input logic [8:0] want);
   exp_q.push_back(want);
   lnk.xfer(1'b0, a, 8'h00);
endtask
task end_sim();
   $display("errors %0d checks %0d", n_errors, tests_run);
   if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
   else
      $display("TEST FAILED");
   $finish;
endtask
initial
begin
   ref_clk = 1'b0;
   forever #10 ref_clk = ~ref_clk;
end
always @(posedge ref_clk)
begin
   seen <= reg_rd;
   cyc++;
   #2;
   uart_tx_in = seed[3];
   dp_in = seed[11];
   if (cyc == 5000)
   begin
      n_errors++;
      end_sim();
   end
end
// the oldest note belongs to the read whose data lands now
always @(negedge ref_clk)
   if (seen)
   begin
      e = exp_q.pop_front();
      if (!e[8])
         chk(reg_rdata, e[7:0]);
   end
initial
begin
   {rst_b, src, line_state, sig, vend} = '0;
   rise_enable = 5'h1f;
   fall_enable = 5'h1f;
   repeat (12) @(posedge ref_clk);
   #2;
   rst_b = 1'b1;
   foreach (rv[i]) rd(rv[i], 9'h000);
   r = rnd();
   lnk.xfer(1'b1, 6'h16, r[7:0]);
   lnk.xfer(1'b1, 6'h17, r[15:8]);
   rd(6'h18, {1'b0, r[7:0] | r[15:8]});
   lnk.xfer(1'b1, 6'h18, r[23:16]);
   rd(6'h17, {1'b0, (r[7:0] | r[15:8]) & ~r[23:16]});
   lnk.xfer(1'b1, 6'h19, 8'hff);
   rd(6'h1a, 9'h0fe);
   lnk.xfer(1'b1, 6'h1b, 8'hff);
   rd(6'h19, 9'h000);
   lnk.xfer(1'b1, 6'h1e, 8'hff);
   rd(6'h1f, 9'h027);
   repeat (8)
   begin
      r = rnd();
      {line_state, fall_enable, rise_enable, src} = r[16:0];
      exp5 = src & ~(rise_enable & fall_enable & 5'h0a);
      rd(6'h13, {4'h0, exp5});
      rd(6'h15, {7'h00, line_state});
   end
   {fall_enable, rise_enable, src} = {5'h00, 5'h1f, 5'h00};
   rd(6'h14, 9'h100);
   rd(6'h14, 9'h000);
   src = 5'h15;
   rd(6'h14, 9'h015);
   rd(6'h14, 9'h000);
   src = 5'h00;
   rd(6'h14, 9'h000);
   fork
      rd(6'h14, 9'h000);
      begin
         @(posedge ref_clk);
         #2;
         src = 5'h02;
      end
   join
   rd(6'h14, 9'h002);
   foreach (ck[i])
   begin
      lnk.car_on(ck[i]);
      repeat (2) @(posedge ref_clk);
      #2;
      chk({uart_tx_route_on, uart_rx_route_on, data1_oe, data2_oe, data2_out, id_pin_pull_low,
         data1_out, dm_uart_out}, {ck[i][2], ck[i][3], 1'b1, ~ck[i][7], 1'b0, ck[i][1],
         ck[i][3] ? dp_in : 1'b1, uart_tx_in});
      lnk.car_off();
      repeat (3) @(posedge ref_clk);
   end
   // id pull-up sits in another register and is taken as on here
   foreach (at[i])
   begin
      lnk.xfer(1'b1, 6'h1d, at[i][12:5]);
      // vendor enable moves with the sources, just after the edge, never at the negedge
      vend = at[i][4];
      sig = at[i][3:1];
      hit = 1'b0;
      repeat (4)
      begin
         @(negedge ref_clk);
         hit |= alt_int;
      end
      chk({7'h00, hit}, {7'h00, at[i][0]});
   end
   end_sim();
end
endmodule
